// ==== rtl/lbm_cfg.svh ====
`ifndef LBM_CFG_SVH
`define LBM_CFG_SVH

`define CLK_HZ 64'd25000000
`define ENTRY_HOLD_S 64'd4
`define ACCEPT_HOLD_S 64'd1
`define SCROLL_STEP_MS 64'd330
`define IDLE_TIMEOUT_MIN 64'd2
`define UNIT_SLOW_S 64'd10
`define UNIT_FAST_S 64'd1

`define OFS_CFG 8'h00
`define OFS_LOWER 8'h04
`define OFS_UPPER 8'h08
`define OFS_USER_LO 8'h0c
`define OFS_USER_HI 8'h10
`define OFS_MIN_SPAN 8'h14
`define OFS_LIM_LO 8'h18
`define OFS_LIM_HI 8'h1c
`define OFS_STATUS 8'h20
`define OFS_VALUE 8'h24

`define CFG_MENU_EN_BIT 0
`define CFG_WR_PROT_BIT 1
`define CFG_DISP_PCT_BIT 2
`define CFG_UNIT_LSB 3
`define CFG_USER_BIT 5
`define CFG_INVERT_BIT 6
`define CFG_SENSOR_K_BIT 7
`define CFG_DP_LSB 8
`define CFG_PRE_LSB 12

`define STAT_POS_LSB 0
`define STAT_MSG_LSB 4
`define STAT_ACTIVE_BIT 8
`define STAT_RANGE_SET_BIT 9

`define RST_MENU_EN 1'b1
`define RST_WR_PROT 1'b0
`define RST_PREAMBLE 5'd5
`define PREAMBLE_MIN 5'd3
`define PREAMBLE_MAX 5'd20
`define RST_MIN_SPAN 16'sd100
`define RST_LIM_LO -16'sd2000
`define RST_LIM_HI 16'sd6000
`define RST_USER_LO 16'sd0
`define RST_USER_HI 16'sd1000

`define FACT_LO 16'sd0
`define FACT_PT_HI 16'sd1000
`define FACT_K_HI 16'sd3000

`define PCT_FULL 16'sd1000
`define BAR_STEP 16'd100
`define BAR_SEGS 10
`define CUR_BASE_UA 16'd4000
`define CUR_UA_PER_STEP 16'd16

`define MENU_LAST 4'd9
`define ITEM_EXIT 4'd0
`define ITEM_CURRENT 4'd1
`define ITEM_PERCENT 4'd2
`define ITEM_UNIT_SLOW 4'd3
`define ITEM_UNIT_FAST 4'd4
`define ITEM_UNIT_OFF 4'd5
`define ITEM_DP_STEP 4'd6
`define ITEM_SET_LO 4'd7
`define ITEM_SET_HI 4'd8
`define ITEM_INVERT 4'd9

`endif

// ==== rtl/lbm_pkg.sv ====
package lbm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HOLD = 3'b010,
		ST_MENU = 3'b100
	} menu_state_e;
	typedef enum logic [2:0] {
		MSG_NONE = 3'h0,
		MSG_EXIT = 3'h1,
		MSG_DONE = 3'h2,
		MSG_WRITE_PROTECTED = 3'h3,
		MSG_PROCESS_TOO_LOW = 3'h4,
		MSG_SPAN_TOO_SMALL = 3'h5,
		MSG_MENU_ACCESS_DENIED = 3'h6
	} msg_e;
	typedef enum logic [1:0] {
		UNIT_SLOW = 2'h0,
		UNIT_FAST = 2'h1,
		UNIT_OFF = 2'h2
	} unit_mode_e;
	typedef logic signed [15:0] value_t;
endpackage

// ==== rtl/btn_if.sv ====
`timescale 1ns/10ps
interface btn_if;
	logic held;
	logic accept;
	logic step;
	logic entry;
	modport src (output held, output accept, output step, output entry);
	modport dst (input held, input accept, input step, input entry);
endinterface

// ==== rtl/button_timer.sv ====
`timescale 1ns/10ps
module button_timer #(
	parameter logic [31:0] ACCEPT_CYC = 32'd2,
	parameter logic [31:0] ENTRY_CYC = 32'd8,
	parameter logic [31:0] REPEAT_CYC = 32'd2
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic pin_n,
	btn_if.src ev
);
	logic meta_ff, sync_ff, nxt_meta, nxt_sync;
	logic [31:0] hold_ff, nxt_hold, rep_ff, nxt_rep;
	logic pressed;

	assign pressed = ~sync_ff;

	always_comb begin
		nxt_meta = pin_n;
		nxt_sync = meta_ff;
		nxt_hold = 32'd0;
		nxt_rep = 32'd0;
		// Saturate just past entry so the entry event fires once per hold
		if (pressed) begin
			nxt_hold = (hold_ff > ENTRY_CYC) ? hold_ff : hold_ff + 32'd1;
		end
		if (pressed && hold_ff > ACCEPT_CYC) begin
			nxt_rep = (rep_ff == REPEAT_CYC - 32'd1) ? 32'd0 : rep_ff + 32'd1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			hold_ff <= 32'd0;
			rep_ff <= 32'd0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			hold_ff <= nxt_hold;
			rep_ff <= nxt_rep;
		end
	end

	assign ev.held = pressed;
	assign ev.accept = pressed && (hold_ff == ACCEPT_CYC);
	assign ev.step = pressed && (hold_ff > ACCEPT_CYC) && (rep_ff == REPEAT_CYC - 32'd1);
	assign ev.entry = pressed && (hold_ff == ENTRY_CYC);
endmodule // button_timer

// ==== rtl/local_button_menu_display.sv ====
// Overview of operation
// - Holding any button about four seconds opens the menu showing the exit prompt.
// - At the exit prompt a one second confirm press leaves the menu.
// - A press counts only when held longer than one second.
// - Holding up or down beyond threshold scrolls one position every 0.33 s.
// - Up moves the selection up one position, down moves it down one.
// - Confirm applies the highlighted option and shows done on success.
// - Two minutes without activity leaves the menu, back to process display.
// - Menu entry with local menu disabled is refused with access denied error.
// - Changes under write protection are refused with write protected error.
// - Menu enabled and protection off by default; both set remotely only.
// - Range or zero command with temperature too low is refused with error.
// - Range change narrower than minimum span is refused with span error.
// - Primary readout shows loop current or percent of range per option.
// - Bar lights one segment per ten percent, none at zero, all at full.
// - Current display puts a letter c symbol before the value.
// - Value readout shows under or over when temperature leaves its limits.
// - Value and unit alternate on a ten or one second cycle, or unit off.
// - User mode rescales temperature linearly onto user start and end values.
// - Range low end maps to 4 mA, high end 20 mA, reversed when inverted.
// - Without range data use factory range 0-100 or 0-300 by sensor.
// - Preamble count configurable from three to twenty inclusive.
// - Decimal point settable from the local menu and remotely.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "lbm_cfg.svh"
module local_button_menu_display import lbm_pkg::*; #(
	parameter logic [31:0] ACCEPT_CYC = 32'(`ACCEPT_HOLD_S * `CLK_HZ),
	parameter logic [31:0] ENTRY_CYC = 32'(`ENTRY_HOLD_S * `CLK_HZ),
	parameter logic [31:0] REPEAT_CYC = 32'(`SCROLL_STEP_MS * `CLK_HZ / 64'd1000),
	parameter logic [31:0] TIMEOUT_CYC = 32'(`IDLE_TIMEOUT_MIN * 64'd60 * `CLK_HZ),
	parameter logic [31:0] UNIT_SLOW_CYC = 32'(`UNIT_SLOW_S * `CLK_HZ),
	parameter logic [31:0] UNIT_FAST_CYC = 32'(`UNIT_FAST_S * `CLK_HZ)
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic btn_up_n,
	input wire logic btn_down_n,
	input wire logic btn_ok_n,
	input wire logic signed [15:0] temp_in,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [9:0] bar_segments,
	output logic [15:0] primary_output_readout,
	output logic current_symbol,
	output logic signed [15:0] value_message_readout,
	output logic show_unit,
	output logic over_ind,
	output logic under_ind,
	output logic [1:0] decimal_point,
	output msg_e message,
	output logic menu_active,
	output logic [3:0] menu_position,
	output logic [15:0] loop_current_ua
);
	function automatic logic signed [31:0] scale_lin(input value_t x, input value_t a,
		input value_t b, input value_t c, input value_t d);
		logic signed [47:0] num;
		logic signed [47:0] den;
		num = (48'(x) - 48'(a)) * (48'(d) - 48'(c));
		den = 48'(b) - 48'(a);
		if (den == 48'sd0) begin
			return 32'(c);
		end
		return 32'(48'(c) + num / den);
	endfunction

	function automatic value_t sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			return 16'sd32767;
		end
		if (v < -32'sd32768) begin
			return -16'sd32768;
		end
		return 16'(v);
	endfunction

	btn_if up_if ();
	btn_if down_if ();
	btn_if ok_if ();

	button_timer #(.ACCEPT_CYC(ACCEPT_CYC), .ENTRY_CYC(ENTRY_CYC), .REPEAT_CYC(REPEAT_CYC))
		u_up (.ref_clk(ref_clk), .resetn(resetn), .pin_n(btn_up_n), .ev(up_if.src));
	button_timer #(.ACCEPT_CYC(ACCEPT_CYC), .ENTRY_CYC(ENTRY_CYC), .REPEAT_CYC(REPEAT_CYC))
		u_down (.ref_clk(ref_clk), .resetn(resetn), .pin_n(btn_down_n), .ev(down_if.src));
	button_timer #(.ACCEPT_CYC(ACCEPT_CYC), .ENTRY_CYC(ENTRY_CYC), .REPEAT_CYC(REPEAT_CYC))
		u_ok (.ref_clk(ref_clk), .resetn(resetn), .pin_n(btn_ok_n), .ev(ok_if.src));

	// Configuration state
	logic menu_en_ff, wr_prot_ff, disp_pct_ff, user_mode_ff, invert_ff, sensor_k_ff;
	logic range_set_ff;
	unit_mode_e unit_mode_ff;
	logic [1:0] dp_ff;
	logic [4:0] preamble_ff;
	value_t lower_ff, upper_ff, user_lo_ff, user_hi_ff, min_span_ff, lim_lo_ff, lim_hi_ff;
	logic nxt_menu_en, nxt_wr_prot, nxt_disp_pct, nxt_user_mode, nxt_invert, nxt_sensor_k;
	logic nxt_range_set;
	unit_mode_e nxt_unit_mode;
	logic [1:0] nxt_dp;
	logic [4:0] nxt_preamble;
	value_t nxt_lower, nxt_upper, nxt_user_lo, nxt_user_hi, nxt_min_span, nxt_lim_lo, nxt_lim_hi;

	// Menu state
	menu_state_e state_ff, nxt_state;
	logic [3:0] pos_ff, nxt_pos;
	msg_e msg_ff, nxt_msg;
	logic [31:0] idle_ff, nxt_idle;
	msg_e verdict;
	logic apply_go;

	value_t eff_lo, eff_hi;
	logic any_entry, any_held, activity;
	logic [4:0] pre_w;

	// Factory range stands until software or the menu sets one
	assign eff_lo = range_set_ff ? lower_ff : `FACT_LO;
	assign eff_hi = range_set_ff ? upper_ff : (sensor_k_ff ? `FACT_K_HI : `FACT_PT_HI);

	assign any_entry = up_if.entry | down_if.entry | ok_if.entry;
	assign any_held = up_if.held | down_if.held | ok_if.held;
	assign activity = up_if.accept | up_if.step | down_if.accept | down_if.step | ok_if.accept;
	assign pre_w = reg_wdata[`CFG_PRE_LSB +: 5];

	// Verdict on the highlighted command, computed before it is applied
	always_comb begin
		verdict = MSG_DONE;
		if (wr_prot_ff) begin
			verdict = MSG_WRITE_PROTECTED;
		end else if (pos_ff == `ITEM_SET_LO) begin
			if (temp_in < lim_lo_ff) begin
				verdict = MSG_PROCESS_TOO_LOW;
			end else if (32'(eff_hi) - 32'(temp_in) < 32'(min_span_ff)) begin
				verdict = MSG_SPAN_TOO_SMALL;
			end
		end else if (pos_ff == `ITEM_SET_HI) begin
			if (temp_in < lim_lo_ff || temp_in <= eff_lo) begin
				verdict = MSG_PROCESS_TOO_LOW;
			end else if (32'(temp_in) - 32'(eff_lo) < 32'(min_span_ff)) begin
				verdict = MSG_SPAN_TOO_SMALL;
			end
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_pos = pos_ff;
		nxt_msg = msg_ff;
		nxt_idle = (idle_ff > TIMEOUT_CYC) ? idle_ff : idle_ff + 32'd1;
		apply_go = 1'b0;
		if (activity) begin
			nxt_idle = 32'd0;
		end
		unique case (state_ff)
			ST_IDLE: begin
				nxt_idle = 32'd0;
				if (any_entry) begin
					if (menu_en_ff) begin
						nxt_state = ST_HOLD;
						nxt_pos = `ITEM_EXIT;
						nxt_msg = MSG_EXIT;
					end else begin
						nxt_msg = MSG_MENU_ACCESS_DENIED;
					end
				end else if (activity) begin
					nxt_msg = MSG_NONE;
				end
			end
			// The entry hold must end before its button can navigate
			ST_HOLD: begin
				if (!any_held) begin
					nxt_state = ST_MENU;
				end
			end
			ST_MENU: begin
				if (up_if.accept || up_if.step) begin
					nxt_pos = (pos_ff == 4'd0) ? `MENU_LAST : pos_ff - 4'd1;
					nxt_msg = (nxt_pos == `ITEM_EXIT) ? MSG_EXIT : MSG_NONE;
				end else if (down_if.accept || down_if.step) begin
					nxt_pos = (pos_ff == `MENU_LAST) ? 4'd0 : pos_ff + 4'd1;
					nxt_msg = (nxt_pos == `ITEM_EXIT) ? MSG_EXIT : MSG_NONE;
				end else if (ok_if.accept) begin
					if (pos_ff == `ITEM_EXIT) begin
						nxt_state = ST_IDLE;
						nxt_msg = MSG_NONE;
					end else begin
						nxt_msg = verdict;
						apply_go = (verdict == MSG_DONE);
					end
				end
			end
		endcase
		if (state_ff != ST_IDLE && idle_ff >= TIMEOUT_CYC) begin
			nxt_state = ST_IDLE;
			nxt_msg = MSG_NONE;
			nxt_pos = `ITEM_EXIT;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			pos_ff <= 4'd0;
			msg_ff <= MSG_NONE;
			idle_ff <= 32'd0;
		end else begin
			state_ff <= nxt_state;
			pos_ff <= nxt_pos;
			msg_ff <= nxt_msg;
			idle_ff <= nxt_idle;
		end
	end

	// Local changes first; a bus write in the same cycle overrides them
	always_comb begin
		nxt_menu_en = menu_en_ff;
		nxt_wr_prot = wr_prot_ff;
		nxt_disp_pct = disp_pct_ff;
		nxt_user_mode = user_mode_ff;
		nxt_invert = invert_ff;
		nxt_sensor_k = sensor_k_ff;
		nxt_range_set = range_set_ff;
		nxt_unit_mode = unit_mode_ff;
		nxt_dp = dp_ff;
		nxt_preamble = preamble_ff;
		nxt_lower = lower_ff;
		nxt_upper = upper_ff;
		nxt_user_lo = user_lo_ff;
		nxt_user_hi = user_hi_ff;
		nxt_min_span = min_span_ff;
		nxt_lim_lo = lim_lo_ff;
		nxt_lim_hi = lim_hi_ff;
		if (apply_go) begin
			case (pos_ff)
				`ITEM_CURRENT: nxt_disp_pct = 1'b0;
				`ITEM_PERCENT: nxt_disp_pct = 1'b1;
				`ITEM_UNIT_SLOW: nxt_unit_mode = UNIT_SLOW;
				`ITEM_UNIT_FAST: nxt_unit_mode = UNIT_FAST;
				`ITEM_UNIT_OFF: nxt_unit_mode = UNIT_OFF;
				`ITEM_DP_STEP: nxt_dp = dp_ff + 2'd1;
				`ITEM_SET_LO: begin
					nxt_lower = temp_in;
					nxt_upper = eff_hi;
					nxt_range_set = 1'b1;
				end
				`ITEM_SET_HI: begin
					nxt_upper = temp_in;
					nxt_lower = eff_lo;
					nxt_range_set = 1'b1;
				end
				`ITEM_INVERT: nxt_invert = ~invert_ff;
				default: nxt_dp = dp_ff;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				`OFS_CFG: begin
					nxt_menu_en = reg_wdata[`CFG_MENU_EN_BIT];
					nxt_wr_prot = reg_wdata[`CFG_WR_PROT_BIT];
					nxt_disp_pct = reg_wdata[`CFG_DISP_PCT_BIT];
					if (reg_wdata[`CFG_UNIT_LSB +: 2] != 2'h3) begin
						nxt_unit_mode = unit_mode_e'(reg_wdata[`CFG_UNIT_LSB +: 2]);
					end
					nxt_user_mode = reg_wdata[`CFG_USER_BIT];
					nxt_invert = reg_wdata[`CFG_INVERT_BIT];
					nxt_sensor_k = reg_wdata[`CFG_SENSOR_K_BIT];
					nxt_dp = reg_wdata[`CFG_DP_LSB +: 2];
					// Out-of-range counts are clamped rather than ignored
					nxt_preamble = (pre_w < `PREAMBLE_MIN) ? `PREAMBLE_MIN :
						(pre_w > `PREAMBLE_MAX) ? `PREAMBLE_MAX : pre_w;
				end
				`OFS_LOWER: begin
					nxt_lower = reg_wdata[15:0];
					nxt_upper = range_set_ff ? upper_ff : eff_hi;
					nxt_range_set = 1'b1;
				end
				`OFS_UPPER: begin
					nxt_upper = reg_wdata[15:0];
					nxt_lower = range_set_ff ? lower_ff : eff_lo;
					nxt_range_set = 1'b1;
				end
				`OFS_USER_LO: nxt_user_lo = reg_wdata[15:0];
				`OFS_USER_HI: nxt_user_hi = reg_wdata[15:0];
				`OFS_MIN_SPAN: nxt_min_span = reg_wdata[15:0];
				`OFS_LIM_LO: nxt_lim_lo = reg_wdata[15:0];
				`OFS_LIM_HI: nxt_lim_hi = reg_wdata[15:0];
				default: nxt_min_span = min_span_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			menu_en_ff <= `RST_MENU_EN;
			wr_prot_ff <= `RST_WR_PROT;
			disp_pct_ff <= 1'b0;
			user_mode_ff <= 1'b0;
			invert_ff <= 1'b0;
			sensor_k_ff <= 1'b0;
			range_set_ff <= 1'b0;
			unit_mode_ff <= UNIT_SLOW;
			dp_ff <= 2'd1;
			preamble_ff <= `RST_PREAMBLE;
			lower_ff <= `FACT_LO;
			upper_ff <= `FACT_PT_HI;
			user_lo_ff <= `RST_USER_LO;
			user_hi_ff <= `RST_USER_HI;
			min_span_ff <= `RST_MIN_SPAN;
			lim_lo_ff <= `RST_LIM_LO;
			lim_hi_ff <= `RST_LIM_HI;
		end else begin
			menu_en_ff <= nxt_menu_en;
			wr_prot_ff <= nxt_wr_prot;
			disp_pct_ff <= nxt_disp_pct;
			user_mode_ff <= nxt_user_mode;
			invert_ff <= nxt_invert;
			sensor_k_ff <= nxt_sensor_k;
			range_set_ff <= nxt_range_set;
			unit_mode_ff <= nxt_unit_mode;
			dp_ff <= nxt_dp;
			preamble_ff <= nxt_preamble;
			lower_ff <= nxt_lower;
			upper_ff <= nxt_upper;
			user_lo_ff <= nxt_user_lo;
			user_hi_ff <= nxt_user_hi;
			min_span_ff <= nxt_min_span;
			lim_lo_ff <= nxt_lim_lo;
			lim_hi_ff <= nxt_lim_hi;
		end
	end

	// Display path
	logic signed [31:0] pct_raw;
	logic [15:0] pct, cur_ua;
	logic [9:0] nxt_bar;
	logic [15:0] nxt_primary, nxt_cur;
	value_t nxt_value;
	logic nxt_csym, nxt_over, nxt_under, nxt_show_unit;
	logic [31:0] unit_cnt_ff, nxt_unit_cnt, unit_period;
	logic [9:0] bar_ff;
	logic [15:0] primary_ff, cur_ff;
	value_t value_ff;
	logic csym_ff, over_ff, under_ff, show_unit_ff;
	logic [31:0] nxt_rdata, rdata_ff;

	always_comb begin
		pct_raw = scale_lin(temp_in, eff_lo, eff_hi, 16'sd0, `PCT_FULL);
		if (pct_raw < 32'sd0) begin
			pct_raw = 32'sd0;
		end else if (pct_raw > 32'(`PCT_FULL)) begin
			pct_raw = 32'(`PCT_FULL);
		end
		pct = invert_ff ? 16'(`PCT_FULL) - pct_raw[15:0] : pct_raw[15:0];
		cur_ua = `CUR_BASE_UA + 16'(pct * `CUR_UA_PER_STEP);
		for (int i = 0; i < `BAR_SEGS; i++) begin
			nxt_bar[i] = (pct >= 16'(i + 1) * `BAR_STEP);
		end
		nxt_primary = disp_pct_ff ? pct : cur_ua;
		nxt_csym = ~disp_pct_ff;
		nxt_cur = cur_ua;
		nxt_value = user_mode_ff ?
			sat16(scale_lin(temp_in, eff_lo, eff_hi, user_lo_ff, user_hi_ff)) : temp_in;
		nxt_over = temp_in > lim_hi_ff;
		nxt_under = temp_in < lim_lo_ff;
		unit_period = (unit_mode_ff == UNIT_FAST) ? UNIT_FAST_CYC : UNIT_SLOW_CYC;
		nxt_unit_cnt = unit_cnt_ff + 32'd1;
		nxt_show_unit = show_unit_ff;
		if (unit_mode_ff == UNIT_OFF) begin
			nxt_unit_cnt = 32'd0;
			nxt_show_unit = 1'b0;
		end else if (unit_cnt_ff >= unit_period - 32'd1) begin
			nxt_unit_cnt = 32'd0;
			nxt_show_unit = ~show_unit_ff;
		end
		nxt_rdata = 32'd0;
		if (reg_rd) begin
			case (reg_addr)
				`OFS_CFG: nxt_rdata = {15'd0, preamble_ff, 2'd0, dp_ff, sensor_k_ff, invert_ff,
					user_mode_ff, unit_mode_ff, disp_pct_ff, wr_prot_ff, menu_en_ff};
				`OFS_LOWER: nxt_rdata = 32'(eff_lo);
				`OFS_UPPER: nxt_rdata = 32'(eff_hi);
				`OFS_USER_LO: nxt_rdata = {16'd0, user_lo_ff};
				`OFS_USER_HI: nxt_rdata = {16'd0, user_hi_ff};
				`OFS_MIN_SPAN: nxt_rdata = {16'd0, min_span_ff};
				`OFS_LIM_LO: nxt_rdata = {16'd0, lim_lo_ff};
				`OFS_LIM_HI: nxt_rdata = {16'd0, lim_hi_ff};
				`OFS_STATUS: nxt_rdata = {22'd0, range_set_ff, state_ff != ST_IDLE, 1'b0,
					msg_ff, pos_ff};
				`OFS_VALUE: nxt_rdata = {16'd0, value_ff};
				default: nxt_rdata = 32'd0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bar_ff <= 10'h000;
			primary_ff <= 16'h0000;
			cur_ff <= 16'h0000;
			csym_ff <= 1'b0;
			value_ff <= 16'sh0000;
			over_ff <= 1'b0;
			under_ff <= 1'b0;
			unit_cnt_ff <= 32'd0;
			show_unit_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			bar_ff <= nxt_bar;
			primary_ff <= nxt_primary;
			cur_ff <= nxt_cur;
			csym_ff <= nxt_csym;
			value_ff <= nxt_value;
			over_ff <= nxt_over;
			under_ff <= nxt_under;
			unit_cnt_ff <= nxt_unit_cnt;
			show_unit_ff <= nxt_show_unit;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign bar_segments = bar_ff;
	assign primary_output_readout = primary_ff;
	assign current_symbol = csym_ff;
	assign value_message_readout = value_ff;
	assign show_unit = show_unit_ff;
	assign over_ind = over_ff;
	assign under_ind = under_ff;
	assign decimal_point = dp_ff;
	assign message = msg_ff;
	assign menu_active = (state_ff != ST_IDLE);
	assign menu_position = pos_ff;
	assign loop_current_ua = cur_ff;
endmodule // local_button_menu_display

// ==== tb/op_model.sv ====
`timescale 1ns/10ps
module op_model (
	input wire logic ref_clk,
	output logic btn_up_n,
	output logic btn_down_n,
	output logic btn_ok_n
);
	initial begin
		btn_up_n = 1'b1;
		btn_down_n = 1'b1;
		btn_ok_n = 1'b1;
	end
	// Hold a button n edges: 0 up, 1 down, 2 ok
	task automatic press(input int b, input int n);
		@(posedge ref_clk);
		btn_up_n <= (b != 0);
		btn_down_n <= (b != 1);
		btn_ok_n <= (b != 2);
		repeat (n) @(posedge ref_clk);
		btn_up_n <= 1'b1;
		btn_down_n <= 1'b1;
		btn_ok_n <= 1'b1;
	endtask
endmodule // op_model

// ==== tb/lbm_chk.sv ====
`timescale 1ns/10ps
module lbm_chk import lbm_pkg::*; #(
	parameter logic [31:0] ACCEPT_CYC = 32'd20,
	parameter logic [31:0] TIMEOUT_CYC = 32'd500
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic btn_up_n,
	input wire logic btn_down_n,
	input wire logic btn_ok_n,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [9:0] bar_segments,
	input wire logic [15:0] primary_output_readout,
	input wire logic current_symbol,
	input wire logic over_ind,
	input wire logic under_ind,
	input wire msg_e message,
	input wire logic menu_active,
	input wire logic [3:0] menu_position,
	input wire logic [15:0] loop_current_ua
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] up_cnt_ff, dn_cnt_ff;
	logic up_prev_ff, dn_prev_ff;
	logic [15:0] quiet_ff;
	// Kept after release; acceptance lags the synchroniser
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			up_cnt_ff <= 8'h00;
			dn_cnt_ff <= 8'h00;
			up_prev_ff <= 1'b1;
			dn_prev_ff <= 1'b1;
			quiet_ff <= 16'h0000;
		end else begin
			up_prev_ff <= btn_up_n;
			dn_prev_ff <= btn_down_n;
			if (!btn_up_n && up_prev_ff) up_cnt_ff <= 8'h01;
			else if (!btn_up_n && up_cnt_ff != 8'hff) up_cnt_ff <= up_cnt_ff + 8'h01;
			if (!btn_down_n && dn_prev_ff) dn_cnt_ff <= 8'h01;
			else if (!btn_down_n && dn_cnt_ff != 8'hff) dn_cnt_ff <= dn_cnt_ff + 8'h01;
			if (!menu_active || !btn_up_n || !btn_down_n || !btn_ok_n) quiet_ff <= 16'h0000;
			else quiet_ff <= quiet_ff + 16'h0001;
		end
	end
	property p_rd0; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside answer cycle");
	property p_bar_thermo; ((bar_segments + 10'h001) & bar_segments) == 10'h000; endproperty
	a_bar_thermo: assert property (p_bar_thermo) else $error("bar not contiguous");
	property p_bar_zero; bar_segments == 10'h000 |-> loop_current_ua < 16'h15e0; endproperty
	a_bar_zero: assert property (p_bar_zero) else $error("bar empty above ten percent");
	property p_bar_full; bar_segments == 10'h3ff |-> loop_current_ua == 16'h4e20; endproperty
	a_bar_full: assert property (p_bar_full) else $error("bar full below full output");
	property p_csym; current_symbol |-> primary_output_readout == loop_current_ua; endproperty
	a_csym: assert property (p_csym) else $error("current readout mismatch");
	property p_pct; !current_symbol |-> primary_output_readout <= 16'h03e8; endproperty
	a_pct: assert property (p_pct) else $error("percent readout above full");
	property p_ovun; !(over_ind && under_ind); endproperty
	a_ovun: assert property (p_ovun) else $error("over and under together");
	property p_entry; $rose(menu_active) |-> message == MSG_EXIT && menu_position == 4'h0; endproperty
	a_entry: assert property (p_entry) else $error("menu opened without exit prompt");
	property p_leave; $fell(menu_active) |-> message == MSG_NONE; endproperty
	a_leave: assert property (p_leave) else $error("message left after menu exit");
	property p_idle; quiet_ff <= 16'(TIMEOUT_CYC) + 16'h0002; endproperty
	a_idle: assert property (p_idle) else $error("menu outlived inactivity limit");
	property p_accept;
		$changed(menu_position) && menu_position != 4'h0 |->
			up_cnt_ff >= ACCEPT_CYC || dn_cnt_ff >= ACCEPT_CYC;
	endproperty
	a_accept: assert property (p_accept) else $error("move on a short press");
	// Bench repeat count is 7
	property p_scroll; $changed(menu_position) |=> $stable(menu_position)[*6]; endproperty
	a_scroll: assert property (p_scroll) else $error("scroll faster than step");
	c_open: cover property ($rose(menu_active));
	c_close: cover property ($fell(menu_active));
	c_full: cover property (bar_segments == 10'h3ff);
endmodule // lbm_chk
bind local_button_menu_display lbm_chk #(.ACCEPT_CYC(ACCEPT_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
	.*);

// ==== tb/local_button_menu_display_bench.sv ====
`timescale 1ns/10ps
module local_button_menu_display_bench import lbm_pkg::*;;
	localparam logic [31:0] CFG0 = 32'h00005101;
	logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic signed [15:0] temp_in = 16'sh01f4;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [9:0] bar_segments;
	logic [15:0] primary_output_readout, loop_current_ua;
	logic signed [15:0] value_message_readout;
	logic current_symbol, show_unit, over_ind, under_ind, menu_active;
	logic btn_up_n, btn_down_n, btn_ok_n;
	logic [1:0] decimal_point;
	logic [3:0] menu_position;
	msg_e message;
	int err_count = 0, checked = 0, cyc = 0, g;
	always #20 ref_clk = ~ref_clk;
	op_model op (.ref_clk(ref_clk), .btn_up_n(btn_up_n), .btn_down_n(btn_down_n),
		.btn_ok_n(btn_ok_n));
	local_button_menu_display #(.ACCEPT_CYC(32'd20), .ENTRY_CYC(32'd80), .REPEAT_CYC(32'd7),
		.TIMEOUT_CYC(32'd500), .UNIT_FAST_CYC(32'd10)) DUT (.*);
	task automatic results();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (e !== s) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task automatic tmp(input logic signed [15:0] t);
		@(posedge ref_clk);
		temp_in <= t;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// Wait out the synchroniser
	task automatic pr(input int b, input int n);
		op.press(b, n);
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic st(input logic act, input logic [3:0] p, input msg_e m);
		chk("menu_active", 32'(act), 32'(menu_active));
		chk("menu_position", 32'(p), 32'(menu_position));
		chk("message", 32'(m), 32'(message));
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(8'h00, CFG0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h3e8);
		rd(8'h30, 32'h0);
		wr(8'h00, CFG0 | 32'h80);
		rd(8'h08, 32'hbb8);
		wr(8'h00, 32'h0001f101);
		rd(8'h00, 32'h00014101);
		wr(8'h00, 32'h00001101);
		rd(8'h00, 32'h00003101);
		wr(8'h00, 32'h00005201);
		tmp(16'sh01f4);
		chk("decimal_point", 32'h2, 32'(decimal_point));
		wr(8'h00, CFG0);
		tmp(16'sh01f4);
		chk("bar", 32'h01f, 32'(bar_segments));
		chk("current", 32'h2ee0, 32'(loop_current_ua));
		chk("primary", 32'h2ee0, 32'(primary_output_readout));
		chk("csym", 32'h1, 32'(current_symbol));
		wr(8'h00, CFG0 | 32'h4);
		tmp(16'sh01f4);
		chk("primary pct", 32'h1f4, 32'(primary_output_readout));
		chk("csym pct", 32'h0, 32'(current_symbol));
		wr(8'h00, CFG0);
		tmp(16'sh0000);
		chk("bar zero", 32'h0, 32'(bar_segments));
		tmp(16'sh03e8);
		chk("bar full", 32'h3ff, 32'(bar_segments));
		chk("current hi", 32'h4e20, 32'(loop_current_ua));
		wr(8'h00, CFG0 | 32'h40);
		tmp(16'sh03e8);
		chk("current inv", 32'hfa0, 32'(loop_current_ua));
		wr(8'h00, CFG0);
		tmp(16'sh1b58);
		chk("over", 32'h2, 32'({over_ind, under_ind}));
		tmp(-16'sh0bb8);
		chk("under", 32'h1, 32'({over_ind, under_ind}));
		wr(8'h10, 32'h7d0);
		wr(8'h00, CFG0 | 32'h20);
		tmp(16'sh01f4);
		chk("user value", 32'h3e8, 32'(value_message_readout));
		wr(8'h00, CFG0 | 32'h8);
		repeat (30) @(posedge ref_clk);
		#1;
		begin : gap
			logic s;
			s = show_unit;
			for (g = 0; g < 100 && show_unit === s; g++) @(posedge ref_clk) #1;
			s = show_unit;
			for (g = 0; g < 100 && show_unit === s; g++) @(posedge ref_clk) #1;
		end
		chk("unit gap", 32'd10, 32'(g));
		wr(8'h00, CFG0 | 32'h10);
		tmp(16'sh03e8);
		chk("unit off", 32'h0, 32'(show_unit));
		wr(8'h00, CFG0);
		pr(2, 90);
		st(1'b1, 4'h0, MSG_EXIT);
		pr(1, 10);
		st(1'b1, 4'h0, MSG_EXIT);
		pr(1, 24);
		st(1'b1, 4'h1, MSG_NONE);
		pr(0, 24);
		pr(0, 24);
		st(1'b1, 4'h9, MSG_NONE);
		pr(2, 24);
		st(1'b1, 4'h9, MSG_DONE);
		chk("inverted", 32'hfa0, 32'(loop_current_ua));
		pr(1, 40);
		st(1'b1, 4'h2, MSG_NONE);
		wr(8'h00, CFG0 | 32'h2);
		pr(2, 24);
		st(1'b1, 4'h2, MSG_WRITE_PROTECTED);
		chk("csym kept", 32'h1, 32'(current_symbol));
		wr(8'h00, CFG0);
		repeat (5) pr(1, 24);
		tmp(-16'sh09c4);
		pr(2, 24);
		st(1'b1, 4'h7, MSG_PROCESS_TOO_LOW);
		tmp(16'sh03b6);
		pr(2, 24);
		st(1'b1, 4'h7, MSG_SPAN_TOO_SMALL);
		tmp(16'sh00c8);
		pr(2, 24);
		st(1'b1, 4'h7, MSG_DONE);
		rd(8'h04, 32'hc8);
		repeat (7) pr(0, 24);
		pr(2, 24);
		st(1'b0, 4'h0, MSG_NONE);
		pr(2, 90);
		repeat (300) @(posedge ref_clk);
		pr(1, 24);
		repeat (300) @(posedge ref_clk);
		chk("still open", 32'h1, 32'(menu_active));
		repeat (300) @(posedge ref_clk);
		st(1'b0, 4'h0, MSG_NONE);
		wr(8'h00, CFG0 & 32'hfffffffe);
		pr(2, 90);
		st(1'b0, 4'h0, MSG_MENU_ACCESS_DENIED);
		results();
	end
endmodule // local_button_menu_display_bench
